// >>> axs_pkg.sv
// package: constants and carrier types for the accelerometer i2c slave port
package axs_pkg;

  // upper six bits of the 7-bit slave address; the select pin supplies bit 0
  localparam logic [5:0] ADDR_UPPER = 6'h0e;
  // direction bit: 1 master reads, 0 master writes
  localparam logic DIR_READ = 1'b1;
  // register pointer width and reset value
  localparam int PTR_W = 8;
  localparam logic [7:0] PTR_RST = 8'h00;
  // register locations at and above this read back as zero
  localparam logic [7:0] REG_LIMIT = 8'h40;
  localparam logic [7:0] RESERVED_VAL = 8'h00;
  // bus rates the port must keep up with
  localparam int FAST_RATE_KHZ = 400;
  localparam int NORMAL_RATE_KHZ = 100;
  localparam int CLK_MHZ = 100;
  // system clocks per scl period at fast mode
  localparam int SCL_FAST_CYC = (CLK_MHZ * 1000) / FAST_RATE_KHZ;
  // fifo depth for written bytes
  localparam int WFIFO_DEPTH = 16;

  // one register write: pointer and byte
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } axs_wr_s;

  // register read request towards the register file
  typedef struct packed {
    logic [7:0] addr;
  } axs_rd_s;

  // protocol states, gray coded along the address-then-data path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b011,
    ST_RXB  = 3'b010,
    ST_RACK = 3'b110,
    ST_TXB  = 3'b111,
    ST_TACK = 3'b101,
    ST_SKIP = 3'b100
  } axs_state_e;

endpackage

// >>> axs_fifo.sv
// file: small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module axs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic push, pop;
  logic [AW:0] fill;

  // full when pointers differ only in the wrap bit
  assign in_ready = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
  assign out_valid = (wp_q != rp_q);
  assign out_data = mem_q[rp_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // occupancy, read only by the full-flag check
  assign fill = wp_q - rp_q;

  // next pointers and storage
  always_comb begin
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
    for (int i = 0; i < DEPTH; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (push) begin
      mem_d[wp_q[AW-1:0]] = in_data;
    end
  end

  // registers; storage needs no reset
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
    mem_q <= mem_d;
  end

  // full flag must mean exactly depth entries held
  a_fifo_full_count: assert property (@(posedge clk_sys) disable iff (!rstn)
    !in_ready |-> fill == DEPTH) else $error("fifo full flag off by one");
endmodule

// >>> axs_i2c_slave.sv
// file: i2c slave port of the accelerometer, protocol engine and write fifo
`timescale 1ns/1ps
module axs_i2c_slave #(
  parameter int FIFO_DEPTH = axs_pkg::WFIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic scl_o,
  output logic scl_oe,
  input wire logic addr_select_pin,
  input wire logic core_powered,
  output axs_pkg::axs_rd_s rd_req,
  input wire logic [7:0] rd_data,
  output axs_pkg::axs_wr_s wr_out,
  output logic wr_valid,
  input wire logic wr_ready,
  input wire logic data_ready,
  output logic int_data_ready,
  output logic busy
);
  import axs_pkg::*;

  // two-stage synchronisers; the first stage feeds only the second
  logic [1:0] scl_s_q, sda_s_q, sel_s_q, pwr_s_q;
  logic scl_q, sda_q;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
      sel_s_q <= 2'b00;
      pwr_s_q <= 2'b00;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
      sel_s_q <= {sel_s_q[0], addr_select_pin};
      pwr_s_q <= {pwr_s_q[0], core_powered};
      scl_q <= scl_s_q[1];
      sda_q <= sda_s_q[1];
    end
  end

  logic scl, sda, pwr, scl_rise, scl_fall, start_ev, stop_ev;
  assign scl = scl_s_q[1];
  assign sda = sda_s_q[1];
  assign pwr = pwr_s_q[1];
  assign scl_rise = scl && !scl_q;
  assign scl_fall = !scl && scl_q;
  assign start_ev = pwr && scl && scl_q && sda_q && !sda;
  assign stop_ev = pwr && scl && scl_q && !sda_q && sda;

  // write fifo: the register side may stall, back-pressure nacks the master
  axs_wr_s fifo_in;
  logic fifo_push, fifo_ready;
  axs_fifo #(
    .WIDTH($bits(axs_wr_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_wfifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .in_data(fifo_in),
    .in_valid(fifo_push),
    .in_ready(fifo_ready),
    .out_data(wr_out),
    .out_valid(wr_valid),
    .out_ready(wr_ready)
  );

  axs_state_e st_q, st_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
  logic [2:0] cnt_q, cnt_d;
  logic busy_q, busy_d, idx_q, idx_d, ack_q, ack_d, oe_q, oe_d, bit_q, bit_d;
  logic [7:0] tx_byte;
  logic [6:0] my_addr;

  // select pin forms the address low bit
  assign my_addr = {ADDR_UPPER, sel_s_q[1]};
  assign tx_byte = (ptr_q >= REG_LIMIT) ? RESERVED_VAL : rd_data;
  assign rd_req.addr = ptr_q;

  // protocol engine next state; scl is oversampled, 250 clocks per fast bit
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    cnt_d = cnt_q;
    busy_d = busy_q;
    idx_d = idx_q;
    ack_d = ack_q;
    oe_d = oe_q;
    bit_d = bit_q;
    fifo_push = 1'b0;
    fifo_in.addr = ptr_q;
    fifo_in.data = sh_q;
    if (!pwr) begin
      st_d = ST_IDLE;
      busy_d = 1'b0;
      oe_d = 1'b0;
    end else if (stop_ev) begin
      // stop ends the transfer and releases sda
      st_d = ST_IDLE;
      busy_d = 1'b0;
      oe_d = 1'b0;
    end else if (start_ev) begin
      // bus busy until stop; restart reenters address phase
      st_d = ST_ADDR;
      busy_d = 1'b1;
      cnt_d = 3'd0;
      oe_d = 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE, ST_SKIP: begin
          oe_d = 1'b0;
        end
        ST_ADDR, ST_RXB: begin
          // bits of an incoming byte sampled on scl rise
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda};
            cnt_d = cnt_q + 3'd1;
            if (cnt_q == 3'd7) begin
              st_d = (st_q == ST_ADDR) ? ST_AACK : ST_RACK;
              ack_d = 1'b0;
            end
          end
        end
        ST_AACK, ST_RACK: begin
          if (scl_fall && !ack_q) begin
            ack_d = 1'b1;
            if (st_q == ST_AACK) begin
              if (sh_q[7:1] == my_addr) begin
                // pull sda low through the ack clock
                oe_d = 1'b1;
                bit_d = 1'b0;
                idx_d = 1'b1;
              end else begin
                // foreign traffic, stay off the bus
                st_d = ST_SKIP;
              end
            end else if (idx_q) begin
              ptr_d = sh_q;
              idx_d = 1'b0;
              oe_d = 1'b1;
              bit_d = 1'b0;
            end else if (fifo_ready) begin
              // byte queued for the register file
              fifo_push = 1'b1;
              ptr_d = ptr_q + 8'd1;
              oe_d = 1'b1;
              bit_d = 1'b0;
            end
          end else if (scl_fall && ack_q) begin
            oe_d = 1'b0;
            cnt_d = 3'd0;
            if (st_q == ST_AACK && sh_q[0] == DIR_READ) begin
              // read returns indexed register after restart
              // first bit driven after scl fall
              st_d = ST_TXB;
              sh_d = {tx_byte[6:0], 1'b0};
              oe_d = !tx_byte[7];
              bit_d = 1'b0;
            end else begin
              st_d = ST_RXB;
            end
          end
        end
        ST_TXB: begin
          // new bit after each scl fall, open drain
          if (scl_fall) begin
            cnt_d = cnt_q + 3'd1;
            if (cnt_q == 3'd7) begin
              st_d = ST_TACK;
              oe_d = 1'b0;
            end else begin
              oe_d = !sh_q[7];
              sh_d = {sh_q[6:0], 1'b0};
            end
          end
        end
        ST_TACK: begin
          if (scl_rise) begin
            ack_d = sda;
            // acked byte advances pointer
            // rd_data follows the pointer, so moving it here has the next byte ready by the fall
            if (!sda) begin
              ptr_d = ptr_q + 8'd1;
            end
          end else if (scl_fall) begin
            if (!ack_q) begin
              st_d = ST_TXB;
              cnt_d = 3'd0;
              sh_d = {tx_byte[6:0], 1'b0};
              oe_d = !tx_byte[7];
            end else begin
              // nak releases sda for stop or restart
              st_d = ST_SKIP;
              oe_d = 1'b0;
            end
          end
        end
      endcase
    end
  end

  // protocol registers
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_q <= ST_IDLE;
      sh_q <= 8'h00;
      ptr_q <= PTR_RST;
      cnt_q <= 3'd0;
      busy_q <= 1'b0;
      idx_q <= 1'b0;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
      bit_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      idx_q <= idx_d;
      ack_q <= ack_d;
      oe_q <= oe_d;
      bit_q <= bit_d;
    end
  end

  // open drain: only ever drives low; scl is never stretched
  assign sda_o = bit_q;
  assign sda_oe = oe_q && pwr;
  assign scl_o = 1'b0;
  assign scl_oe = 1'b0;
  assign busy = busy_q;

  logic int_q, int_d;
  always_comb begin
    int_d = data_ready && pwr;
  end
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      int_q <= 1'b0;
    end else begin
      int_q <= int_d;
    end
  end
  assign int_data_ready = int_q;

  localparam int MIN_HALF = SCL_FAST_CYC / 2;

  // assertions
  a_start_busy: assert property (@(posedge clk_sys) disable iff (!rstn)
    start_ev |=> busy) else $error("start did not mark bus busy");
  a_stop_release: assert property (@(posedge clk_sys) disable iff (!rstn)
    stop_ev |=> !busy && !sda_oe) else $error("stop did not end transfer");
  a_addr_match: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q == ST_AACK && scl_fall && !ack_q && sh_q[7:1] != my_addr && pwr
    && !start_ev && !stop_ev) |=> st_q == ST_SKIP) else $error("mismatched address not skipped");
  a_skip_quiet: assert property (@(posedge clk_sys) disable iff (!rstn)
    st_q == ST_SKIP |-> !sda_oe) else $error("sda driven for foreign traffic");
  a_unpowered: assert property (@(posedge clk_sys) disable iff (!rstn)
    !pwr |-> !sda_oe ##1 (!busy_q && !sda_oe)) else $error("bus touched while unpowered");
  a_ack_low: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q inside {ST_AACK, ST_RACK}) && sda_oe |-> sda_o == 1'b0) else $error("ack not low");
  a_tx_after_fall: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q == ST_TXB) && $changed(oe_q) && !$past(stop_ev) && !$past(start_ev)
    |-> $past(scl_fall)) else $error("tx bit changed outside scl low");
  a_nak_release: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q == ST_TACK && scl_fall && ack_q) |=> !sda_oe) else $error("sda held after nak");
  a_burst_incr: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q == ST_TACK && scl_rise && !sda && pwr && !stop_ev)
    |=> ptr_q == $past(ptr_q) + 8'd1) else $error("burst read pointer not advanced");
  a_write_incr: assert property (@(posedge clk_sys) disable iff (!rstn)
    fifo_push |=> ptr_q == $past(ptr_q) + 8'd1) else $error("write pointer not advanced");
  a_int_follow: assert property (@(posedge clk_sys) disable iff (!rstn)
    data_ready && pwr |=> int_data_ready) else $error("interrupt did not follow data ready");
  a_ack_in_time: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q == ST_AACK && scl_fall && !ack_q && sh_q[7:1] == my_addr && pwr
    && !start_ev && !stop_ev) |-> ##[1:MIN_HALF] sda_oe) else $error("ack late for fast mode");

  c_write: cover property (@(posedge clk_sys) disable iff (!rstn) fifo_push);
  c_read: cover property (@(posedge clk_sys) disable iff (!rstn) st_q == ST_TXB);
  c_nak: cover property (@(posedge clk_sys) disable iff (!rstn) st_q == ST_TACK && scl_fall && ack_q);
  c_foreign: cover property (@(posedge clk_sys) disable iff (!rstn) st_q == ST_SKIP);
endmodule

// >>> axs_i2c_master.sv
// i2c bus master model that paces scl and sda from the system clock
`timescale 1ns/1ps
module axs_i2c_master (
  input wire logic clk_sys,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // half scl period in system clocks; 8 makes the 160 ns link clock
  int half = 8;
  int unstable = 0;
  // idle bus: scl stands still high, sda left to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // same sequence serves as restart, never a stop in between
  task automatic start();
    sda_low = 1'b0;
    tick(half / 2);
    scl = 1'b1;
    tick(half / 2);
    sda_low = 1'b1;
    tick(half / 2);
    scl = 1'b0;
    tick(half / 2);
  endtask
  // sda rises while scl is high
  task automatic stop();
    sda_low = 1'b1;
    tick(half / 2);
    scl = 1'b1;
    tick(half / 2);
    sda_low = 1'b0;
    tick(half);
  endtask
  // data moves only mid low phase; sda must not move while scl is high
  task automatic bit_xfer(input logic b, output logic r);
    sda_low = !b;
    tick(half / 2);
    scl = 1'b1;
    tick(2);
    r = sda;
    tick(half - 2);
    if (sda !== r) unstable++;
    scl = 1'b0;
    tick(half / 2);
  endtask
  // msb first, then sda released for the receiver's ack
  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(b[i], r);
    bit_xfer(1'b1, r);
    ack = !r;
  endtask
  // ack keeps a burst going, nak ends it before stop
  task automatic read_byte(input logic nak, output logic [7:0] b, output logic rel);
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, b[i]);
    bit_xfer(nak, rel);
  endtask
endmodule

// >>> accel_i2c_slave_port_test.sv
// self-checking bench for the accelerometer i2c slave port
`timescale 1ns/1ps
module accel_i2c_slave_port_test;
  import axs_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic sel = 1'b1;
  logic pwr = 1'b1;
  logic wr_ready = 1'b0;
  logic data_ready = 1'b0;
  logic sda_o, sda_oe, scl_o, scl_oe, scl_m, sda_low, int_dr, busy, wr_valid;
  int oe_cnt = 0;
  wire logic sda_w, scl_w;
  axs_rd_s rd_req;
  axs_wr_s wr_out;
  logic [7:0] rd_data;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  always #5 clk_sys = ~clk_sys;
  // open-drain wires with pull-ups: low if any party pulls
  assign sda_w = !(sda_low || (sda_oe && !sda_o));
  assign scl_w = !(!scl_m || (scl_oe && !scl_o));
  // register file stand-in answers in the same cycle, nonzero except at 8'h96
  assign rd_data = rd_req.addr ^ 8'h96;
  // counts cycles with sda pulled by the port; scenarios compare before and after
  always @(posedge clk_sys) if (sda_oe === 1'b1) oe_cnt++;

  axs_i2c_slave axs_i2c_slave_i (.clk_sys(clk_sys), .rstn(rstn), .scl_i(scl_w),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .scl_o(scl_o), .scl_oe(scl_oe),
    .addr_select_pin(sel), .core_powered(pwr), .rd_req(rd_req), .rd_data(rd_data),
    .wr_out(wr_out), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .data_ready(data_ready), .int_data_ready(int_dr), .busy(busy));
  axs_i2c_master axs_i2c_master_i (.clk_sys(clk_sys), .sda(sda_w), .scl(scl_m),
    .sda_low(sda_low));

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask
  // expected read value; places at or above the limit read zero
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    return (a < REG_LIMIT) ? (a ^ 8'h96) : 8'h00;
  endfunction
  // address byte then register index, both expected to be acked
  task automatic head(input logic [7:0] a, input logic [7:0] idx);
    logic ack;
    axs_i2c_master_i.start();
    check(16'(busy), 16'h1);
    axs_i2c_master_i.write_byte(a, ack);
    check(16'(ack), 16'h1);
    axs_i2c_master_i.write_byte(idx, ack);
    check(16'(ack), 16'h1);
  endtask
  // single write lands in the fifo with its index
  task automatic t_write();
    logic ack;
    head(8'h3a, 8'h10);
    axs_i2c_master_i.write_byte(8'h5a, ack);
    check(16'(ack), 16'h1);
    axs_i2c_master_i.stop();
    check(16'(busy), 16'h0);
    check(16'(wr_valid), 16'h1);
    check(wr_out, 16'h105a);
    wr_ready = 1'b1;
    tick(1);
    wr_ready = 1'b0;
    tick(1);
  endtask
  // burst write fills the fifo until it refuses, then drain in order
  task automatic t_fill();
    logic ack;
    head(8'h3a, 8'h20);
    for (int i = 0; i < 16; i++) begin
      axs_i2c_master_i.write_byte(8'hc0 + 8'(i), ack);
      check(16'(ack), 16'h1);
    end
    axs_i2c_master_i.write_byte(8'hff, ack);
    check(16'(ack), 16'h0);
    axs_i2c_master_i.stop();
    for (int i = 0; i < 16; i++) begin
      check(16'(wr_valid), 16'h1);
      check(wr_out, {8'h20 + 8'(i), 8'hc0 + 8'(i)});
      wr_ready = 1'b1;
      tick(1);
      wr_ready = 1'b0;
      tick(1);
    end
    check(16'(wr_valid), 16'h0);
  endtask
  // random read via restart, burst across the reserved boundary
  task automatic t_read(input logic [7:0] idx, input int n, input int hf);
    logic ack, rel;
    logic [7:0] b;
    axs_i2c_master_i.half = hf;
    head(8'h3a, idx);
    axs_i2c_master_i.start();
    axs_i2c_master_i.write_byte(8'h3b, ack);
    check(16'(ack), 16'h1);
    for (int k = 0; k < n; k++) begin
      axs_i2c_master_i.read_byte(k == n - 1, b, rel);
      check(16'(b), 16'(exp_rd(idx + 8'(k))));
    end
    check(16'(rel), 16'h1);
    axs_i2c_master_i.stop();
    check(16'(busy), 16'h0);
    axs_i2c_master_i.half = 8;
  endtask
  // other select level: old address is foreign, new one answers
  task automatic t_foreign();
    logic ack;
    int base;
    sel = 1'b0;
    tick(8);
    base = oe_cnt;
    axs_i2c_master_i.start();
    axs_i2c_master_i.write_byte(8'h3a, ack);
    check(16'(ack), 16'h0);
    axs_i2c_master_i.write_byte(8'h11, ack);
    axs_i2c_master_i.stop();
    check(16'(oe_cnt - base), 16'h0);
    check(16'(wr_valid), 16'h0);
    axs_i2c_master_i.start();
    axs_i2c_master_i.write_byte(8'h38, ack);
    check(16'(ack), 16'h1);
    axs_i2c_master_i.stop();
    sel = 1'b1;
    tick(8);
  endtask
  // core unpowered: bus ignored and ready flag held off
  task automatic t_power();
    logic ack;
    int base;
    pwr = 1'b0;
    data_ready = 1'b1;
    tick(8);
    check(16'(int_dr), 16'h0);
    base = oe_cnt;
    axs_i2c_master_i.start();
    check(16'(busy), 16'h0);
    axs_i2c_master_i.write_byte(8'h3a, ack);
    check(16'({scl_oe, scl_o}), 16'h0);
    axs_i2c_master_i.stop();
    check(16'(oe_cnt - base), 16'h0);
    pwr = 1'b1;
    tick(8);
    check(16'(int_dr), 16'h1);
    data_ready = 1'b0;
    tick(4);
    check(16'(int_dr), 16'h0);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard well above the slow 100 khz read
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 90000) begin
      n_errors++;
      summarize();
    end
  end
  // main sequence
  initial begin
    tick(20);
    rstn = 1'b1;
    tick(6);
    t_write();
    t_fill();
    t_read(8'h3e, 3, 8);
    t_read(8'h05, 1, 500);
    t_foreign();
    t_power();
    check(16'(axs_i2c_master_i.unstable), 16'h0);
    summarize();
  end
endmodule
